// [rtl/iops_defines.svh]
`ifndef IOPS_DEFINES_SVH
`define IOPS_DEFINES_SVH

// Register byte addresses, low 20 bits
`define IOPS_ADDR_W          20
`define IOPS_PORTB_DIR_ADDR  20'hEE00A
`define IOPS_PORTB_DATA_ADDR 20'hFFFDA

// Reset and read-back values
`define IOPS_PORTB_DIR_RST   8'h00
`define IOPS_PORTB_DATA_RST  8'h00
`define IOPS_WO_READ_VAL     8'hFF
`define IOPS_UNMAPPED_VAL    8'h00

// Clock select codes
`define IOPS_PSC_EXT_A       3'h4
`define IOPS_PSC_EXT_B       3'h5
`define IOPS_PSC_EXT_C       3'h6
`define IOPS_CKS_EXT_EDGE    3'h5

// I/O control field positions
`define IOPS_IOCTL_CAPT_BIT  2

`endif

// [rtl/iops_pkg.sv]
package iops_pkg;

	typedef struct packed {
		logic       ch0_pulse_width_mode;
		logic       phase_count_mode;
		logic [2:0] ch0_io_control;
		logic [2:0] counter0_prescale;
		logic [2:0] counter1_prescale;
		logic [2:0] counter2_prescale;
		logic [2:0] byte_timer0_clk;
		logic [2:0] byte_timer1_clk;
		logic [2:0] byte_timer3_clk;
	} iops_timer_cfg_t;

	typedef struct packed {
		logic [2:0] direction;
		logic [2:0] pattern_enable;
		logic [2:0] data;
		logic [2:0] pattern;
	} iops_porta_cfg_t;

	typedef struct packed {
		logic [7:0] active;
		logic [7:0] level;
		logic [7:0] oe_n;
	} iops_portb_alt_t;

	typedef enum logic [1:0] {
		IOPS_MODE_RUN    = 2'b00,
		IOPS_MODE_SWSTBY = 2'b01,
		IOPS_MODE_HWSTBY = 2'b10
	} iops_mode_t;

endpackage

// [rtl/iops_porta_sel.sv]
`timescale 1ns/100ps
`default_nettype none
`include "iops_defines.svh"

module iops_porta_sel
	import iops_pkg::*;
(
	// Configuration
	input  wire iops_timer_cfg_t tcfg,
	input  wire iops_porta_cfg_t acfg,
	// Timer output
	input  wire logic            ch0_compare_a,
	// Pin drive
	output logic [2:0]           pin_out,
	output logic [2:0]           pin_oe_n,
	// Function selects
	output logic                 ch0_capture_a_sel,
	output logic                 ext_clock_a_sel,
	output logic                 ext_clock_b_sel,
	output logic                 ext_clock_c_sel
);

	function automatic logic any_psc(input iops_timer_cfg_t c,
		input logic [2:0] code);
		any_psc = (c.counter0_prescale == code)
			|| (c.counter1_prescale == code)
			|| (c.counter2_prescale == code);
	endfunction

	// 101 or 11x
	function automatic logic cks_ext(input logic [2:0] cks);
		cks_ext = (cks == `IOPS_CKS_EXT_EDGE) || (cks[2:1] == 2'b11);
	endfunction

	logic cmp_a_sel;

	always_comb begin
		cmp_a_sel = tcfg.ch0_pulse_width_mode
			|| (!tcfg.ch0_io_control[`IOPS_IOCTL_CAPT_BIT]
			&& (tcfg.ch0_io_control[1:0] != 2'b00)); // see R1
		ch0_capture_a_sel =
			tcfg.ch0_io_control[`IOPS_IOCTL_CAPT_BIT]; // see R3
		ext_clock_c_sel = any_psc(tcfg, `IOPS_PSC_EXT_C)
			|| cks_ext(tcfg.byte_timer0_clk); // see R4
		ext_clock_b_sel = tcfg.phase_count_mode
			|| any_psc(tcfg, `IOPS_PSC_EXT_B)
			|| cks_ext(tcfg.byte_timer3_clk); // see R6
		ext_clock_a_sel = tcfg.phase_count_mode
			|| any_psc(tcfg, `IOPS_PSC_EXT_A)
			|| cks_ext(tcfg.byte_timer1_clk); // see R8
		for (int i = 0; i < 3; i++) begin
			// see R2 see R5 see R7
			pin_oe_n[i] = !acfg.direction[i];
			pin_out[i]  = acfg.pattern_enable[i] ? acfg.pattern[i]
				: acfg.data[i];
		end
		if (cmp_a_sel) begin
			pin_oe_n[2] = 1'b0; // see R1
			pin_out[2]  = ch0_compare_a;
		end
	end

endmodule

`default_nettype wire

// [rtl/iops_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "iops_defines.svh"

// What this block does
// R1: Port A pin 2 drives channel-0 compare A in PWM or compare setting.
// R2: Otherwise pin 2 is input, general output or pattern output.
// R3: Pin 2 feeds channel-0 capture A whenever capture bit is set.
// R4: Pin 2 is clock C for prescale 110 or byte timer 0 101/11x.
// R5: Pin 1 is input, general output or pattern output by direction/enable.
// R6: Pin 1 is clock B for phase count, prescale 101, timer 3 clock.
// R7: Pin 0 is input, general output or pattern output by direction/enable.
// R8: Pin 0 is clock A for phase count, prescale 100, timer 1 clock.
// R9: Port B is 8-bit; reset and hardware standby return it to I/O.
// R10: Port B pin drives when direction bit is 1, input when 0.
// R11: Software sets direction bit too when using a pin for patterns.
// R12: Port B direction is write-only and reads back all ones.
// R13: Direction clears on reset/hardware standby, kept in software standby.
// R14: General outputs keep driving through software standby.
// R15: Port B data is 8-bit read/write and drives general outputs.
// R16: Port B read gives data register bit where direction is 1.
// R17: Port B read gives sensed pin level where direction is 0.
// R18: Data clears on reset/hardware standby, kept in software standby.
// R19: Assigned alternate functions override direction and data for driving.
module iops_top
	import iops_pkg::*;
#(
	parameter int PORT_W = 8
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// Power state
	input  wire iops_mode_t               mode,
	// Register port
	input  wire logic [`IOPS_ADDR_W-1:0]  addr,
	input  wire logic [7:0]               wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output logic [7:0]                    rdata,
	// Port A low pins configuration
	input  wire iops_timer_cfg_t          tcfg,
	input  wire iops_porta_cfg_t          acfg,
	input  wire logic                     ch0_compare_a,
	input  wire logic [2:0]               porta_in,
	output logic [2:0]                    porta_out,
	output logic [2:0]                    porta_oe_n,
	// Port A timer inputs
	output logic                          ch0_capture_a,
	output logic                          ext_clock_a,
	output logic                          ext_clock_b,
	output logic                          ext_clock_c,
	// Port B alternate functions
	input  wire iops_portb_alt_t          balt,
	input  wire logic [PORT_W-1:0]        portb_pattern,
	input  wire logic [PORT_W-1:0]        portb_pattern_en,
	// Port B pins
	input  wire logic [PORT_W-1:0]        portb_in,
	output logic [PORT_W-1:0]             portb_out,
	output logic [PORT_W-1:0]             portb_oe_n,
	output logic [PORT_W-1:0]             portb_sensed
);

	// Pin synchronisers; first stage is read by the second only
	logic [2:0]        a_meta_q, a_sync_q;
	logic [PORT_W-1:0] b_meta_q, b_sync_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			a_meta_q <= '0;
			a_sync_q <= '0;
			b_meta_q <= '0;
			b_sync_q <= '0;
		end else begin
			a_meta_q <= porta_in;
			a_sync_q <= a_meta_q;
			b_meta_q <= portb_in;
			b_sync_q <= b_meta_q;
		end
	end

	// Port B registers
	logic [PORT_W-1:0] dir_q, dir_d;
	logic [PORT_W-1:0] data_q, data_d;
	logic [7:0]        rdata_q, rdata_d;
	logic              hw_stby;
	logic              sel_dir, sel_data;

	assign hw_stby  = (mode == IOPS_MODE_HWSTBY);
	assign sel_dir  = (addr == `IOPS_PORTB_DIR_ADDR);
	assign sel_data = (addr == `IOPS_PORTB_DATA_ADDR);

	always_comb begin
		dir_d   = dir_q;
		data_d  = data_q;
		rdata_d = 8'h00;
		if (hw_stby) begin
			dir_d  = PORT_W'(`IOPS_PORTB_DIR_RST); // see R13
			data_d = PORT_W'(`IOPS_PORTB_DATA_RST); // see R18
		end else if (wr) begin
			// Software standby leaves both registers untouched
			if (sel_dir)
				dir_d = wdata[PORT_W-1:0]; // see R13
			if (sel_data)
				data_d = wdata[PORT_W-1:0]; // see R15
		end
		if (rd) begin
			if (sel_dir)
				rdata_d = `IOPS_WO_READ_VAL; // see R12
			else if (sel_data)
				rdata_d = 8'((dir_q & data_q)
					| (~dir_q & b_sync_q)); // see R16 see R17
			else
				rdata_d = `IOPS_UNMAPPED_VAL;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_q   <= PORT_W'(`IOPS_PORTB_DIR_RST); // see R13
			data_q  <= PORT_W'(`IOPS_PORTB_DATA_RST); // see R18
			rdata_q <= 8'h00;
		end else begin
			dir_q   <= dir_d;
			data_q  <= data_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;

	// Port B pin drive, one cell per pin, each output straight from a flop
	for (genvar gi = 0; gi < PORT_W; gi++) begin : g_pin_b
		logic out_d, oe_n_d, out_q, oe_n_q;

		always_comb begin
			if (hw_stby) begin
				out_d  = 1'b0; // see R9
				oe_n_d = 1'b1;
			end else if (balt.active[gi]) begin
				out_d  = balt.level[gi]; // see R19
				oe_n_d = balt.oe_n[gi];
			end else if (portb_pattern_en[gi]) begin
				// Pattern needs the direction bit as well
				out_d  = portb_pattern[gi]; // see R11
				oe_n_d = !dir_q[gi];
			end else begin
				// Holds through software standby
				out_d  = data_q[gi]; // see R10 see R14 see R15
				oe_n_d = !dir_q[gi]; // see R10
			end
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				out_q  <= 1'b0;
				oe_n_q <= 1'b1; // see R9
			end else begin
				out_q  <= out_d;
				oe_n_q <= oe_n_d;
			end
		end

		assign portb_out[gi]  = out_q;
		assign portb_oe_n[gi] = oe_n_q;
	end
	assign portb_sensed = b_sync_q;

	// Port A low pins
	logic [2:0] a_out_c, a_oe_n_c;
	logic       cap_sel, clka_sel, clkb_sel, clkc_sel;

	iops_porta_sel i_iops_porta_sel (
		.tcfg              (tcfg),
		.acfg              (acfg),
		.ch0_compare_a     (ch0_compare_a),
		.pin_out           (a_out_c),
		.pin_oe_n          (a_oe_n_c),
		.ch0_capture_a_sel (cap_sel),
		.ext_clock_a_sel   (clka_sel),
		.ext_clock_b_sel   (clkb_sel),
		.ext_clock_c_sel   (clkc_sel)
	);

	logic [2:0] a_out_q, a_oe_n_q, a_out_d, a_oe_n_d;
	logic [3:0] tin_q, tin_d;

	always_comb begin
		a_out_d  = a_out_c;
		// Hardware standby releases the pins even if a timer still claims them
		a_oe_n_d = hw_stby ? 3'h7 : a_oe_n_c;
		tin_d[0] = cap_sel  & a_sync_q[2]; // see R3
		tin_d[1] = clkc_sel & a_sync_q[2]; // see R4
		tin_d[2] = clkb_sel & a_sync_q[1]; // see R6
		tin_d[3] = clka_sel & a_sync_q[0]; // see R8
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			a_out_q  <= '0;
			a_oe_n_q <= '1;
			tin_q    <= '0;
		end else begin
			a_out_q  <= a_out_d;
			a_oe_n_q <= a_oe_n_d;
			tin_q    <= tin_d;
		end
	end

	assign porta_out     = a_out_q;
	assign porta_oe_n    = a_oe_n_q;
	assign ch0_capture_a = tin_q[0];
	assign ext_clock_c   = tin_q[1];
	assign ext_clock_b   = tin_q[2];
	assign ext_clock_a   = tin_q[3];

endmodule

`default_nettype wire

// [test/iops_board.sv]
`timescale 1ns/100ps
`default_nettype none
module iops_board #(
	parameter int W = 8
) (
	// Device side
	input wire logic [W-1:0] dout,
	input wire logic [W-1:0] oe_n,
	// Board side
	input wire logic [W-1:0] ext,
	output logic [W-1:0]     pin
);
	// Released pins show the board's own level, never the last drive
	assign pin = (~oe_n & dout) | (oe_n & ext);
endmodule
`default_nettype wire

// [test/iops_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "iops_defines.svh"
module iops_monitor
	import iops_pkg::*;
#(
	parameter int PORT_W = 8
) (
	// Clock, reset, mode
	input wire logic                    clk,
	input wire logic                    rst_n,
	input wire iops_mode_t              mode,
	// Register port
	input wire logic [`IOPS_ADDR_W-1:0] addr,
	input wire logic                    rd,
	input wire logic [7:0]              rdata,
	// Pins and timer inputs
	input wire logic [2:0]              porta_in,
	input wire logic [2:0]              porta_oe_n,
	input wire logic [PORT_W-1:0]       portb_oe_n,
	input wire logic                    ext_clock_a,
	input wire logic                    ext_clock_b,
	input wire logic                    ext_clock_c,
	input wire logic                    ch0_capture_a
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_hw_b; mode == IOPS_MODE_HWSTBY |=> &portb_oe_n; endproperty
	a_hw_b: assert property (p_hw_b)
		else $error("port b driven in standby");
	property p_hw_a;
		mode == IOPS_MODE_HWSTBY |=> porta_oe_n == 3'h7;
	endproperty
	a_hw_a: assert property (p_hw_a)
		else $error("port a driven in standby");
	property p_dir_rd;
		rd && addr == `IOPS_PORTB_DIR_ADDR |=> rdata == `IOPS_WO_READ_VAL;
	endproperty
	a_dir_rd: assert property (p_dir_rd)
		else $error("direction read not all ones");
	property p_idle; !rd |=> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle)
		else $error("read data without read");
	// Sync chain plus output register gives three cycles
	property p_cka; ext_clock_a |-> $past(porta_in[0], 3); endproperty
	a_cka: assert property (p_cka)
		else $error("clock a without pin");
	property p_ckb; ext_clock_b |-> $past(porta_in[1], 3); endproperty
	a_ckb: assert property (p_ckb)
		else $error("clock b without pin");
	property p_ckc; ext_clock_c |-> $past(porta_in[2], 3); endproperty
	a_ckc: assert property (p_ckc)
		else $error("clock c without pin");
	property p_cap; ch0_capture_a |-> $past(porta_in[2], 3); endproperty
	a_cap: assert property (p_cap)
		else $error("capture without pin");

	cover property (ext_clock_c);
	cover property (mode == IOPS_MODE_SWSTBY && portb_oe_n != '1);
	cover property (rd && addr == `IOPS_PORTB_DIR_ADDR);
endmodule
`default_nettype wire

// [test/iops_top_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "iops_defines.svh"
module iops_top_bench;
	import iops_pkg::*;
	localparam logic [19:0] DIR = `IOPS_PORTB_DIR_ADDR;
	localparam logic [19:0] DAT = `IOPS_PORTB_DATA_ADDR;
	logic            clk, rst_n, wr, rd, cmp, cap, cka, ckb, ckc;
	logic [19:0]     addr;
	logic [7:0]      wdata, rdata, pat, pen, bin, bout, boe_n, bext, bsen;
	logic [2:0]      ain, aout, aoe_n, aext;
	iops_mode_t      mode;
	iops_timer_cfg_t tcfg;
	iops_porta_cfg_t acfg;
	iops_portb_alt_t balt;
	int              failures, checked;

	iops_top i_iops_top (.clk(clk), .rst_n(rst_n), .mode(mode), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tcfg(tcfg),
		.acfg(acfg), .ch0_compare_a(cmp), .porta_in(ain), .porta_out(aout),
		.porta_oe_n(aoe_n), .ch0_capture_a(cap), .ext_clock_a(cka),
		.ext_clock_b(ckb), .ext_clock_c(ckc), .balt(balt),
		.portb_pattern(pat), .portb_pattern_en(pen), .portb_in(bin),
		.portb_out(bout), .portb_oe_n(boe_n), .portb_sensed(bsen));
	iops_board i_iops_board (.dout(bout), .oe_n(boe_n), .ext(bext), .pin(bin));
	iops_board #(.W(3)) i_iops_board_a (.dout(aout), .oe_n(aoe_n),
		.ext(aext), .pin(ain));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wreg(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rchk(input logic [19:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic t_regs;
		rchk(DIR, `IOPS_WO_READ_VAL);
		rchk(DAT, 8'h3C);
		chk(bsen, 8'h3C);
		rchk(20'h00000, 8'h00);
		chk(boe_n, 8'hFF);
		wreg(DIR, 8'hFF);
		rchk(DAT, 8'h00);
		wreg(DIR, 8'h0F);
		wreg(DAT, 8'hA5);
		cyc(3);
		chk(boe_n, 8'hF0);
		chk(bout & 8'h0F, 8'h05);
		rchk(DAT, 8'h35);
	endtask

	task automatic t_stby;
		@(posedge clk);
		mode <= IOPS_MODE_SWSTBY;
		cyc(8);
		chk(boe_n, 8'hF0);
		chk(bout & 8'h0F, 8'h05);
		@(posedge clk);
		mode <= IOPS_MODE_RUN;
		rchk(DAT, 8'h35);
		@(posedge clk);
		mode <= IOPS_MODE_HWSTBY;
		wreg(DAT, 8'hFF);
		cyc(2);
		chk(boe_n, 8'hFF);
		@(posedge clk);
		mode <= IOPS_MODE_RUN;
		rchk(DAT, 8'h3C);
		wreg(DIR, 8'hFF);
		rchk(DAT, 8'h00);
	endtask

	task automatic t_pat;
		@(posedge clk);
		pat <= 8'h5A;
		pen <= 8'h0F;
		cyc(3);
		chk(bout, 8'h0A);
		wreg(DIR, 8'hF0);
		cyc(2);
		chk(boe_n, 8'h0F);
		@(posedge clk);
		balt <= {8'h81, 8'h01, 8'h00};
		cyc(3);
		chk(bout & 8'h81, 8'h01);
		chk(boe_n & 8'h81, 8'h00);
	endtask

	task automatic t_porta;
		@(posedge clk);
		acfg <= {3'h7, 3'h2, 3'h1, 3'h2};
		cmp <= 1'b1;
		cyc(3);
		chk({5'h00, aout}, 8'h03);
		chk({5'h00, aoe_n}, 8'h00);
		@(posedge clk);
		tcfg <= {1'b1, 22'h0};
		cyc(3);
		chk({5'h00, aout}, 8'h07);
		@(posedge clk);
		tcfg <= {2'b00, 3'h1, 18'h0};
		cyc(3);
		chk({5'h00, aout}, 8'h07);
		@(posedge clk);
		tcfg <= {2'b00, 3'h5, 18'h0};
		cyc(3);
		chk({5'h00, aout}, 8'h03);
	endtask

	task automatic t_clocks;
		@(posedge clk);
		acfg <= '0;
		aext <= 3'h7;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			tcfg <= {8'h00, 3'h4 + 3'(i), 12'h000};
			cyc(5);
			chk({5'h00, ckc, ckb, cka}, 8'h01 << i);
		end
		@(posedge clk);
		tcfg <= {2'b01, 3'h4, 9'h000, 3'h5, 3'h0, 3'h7};
		cyc(5);
		chk({4'h0, cap, ckc, ckb, cka}, 8'h0F);
		@(posedge clk);
		tcfg <= {14'h0000, 3'h0, 3'h6, 3'h0};
		cyc(5);
		chk({5'h00, ckc, ckb, cka}, 8'h01);
		@(posedge clk);
		aext <= 3'h0;
		cyc(5);
		chk({5'h00, ckc, ckb, cka}, 8'h00);
	endtask

	task automatic t_reset;
		wreg(DIR, 8'h0F);
		wreg(DAT, 8'hC3);
		cyc(2);
		chk(boe_n, 8'hF0);
		@(posedge clk);
		rst_n <= 1'b0;
		cyc(2);
		chk(boe_n, 8'hFF);
		chk(bout, 8'h00);
		@(posedge clk);
		rst_n <= 1'b1;
		// Pin level needs the two synchroniser stages first
		cyc(2);
		rchk(DAT, 8'h3C);
		wreg(DIR, 8'hFF);
		rchk(DAT, 8'h00);
	endtask

	task automatic wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		mode = IOPS_MODE_RUN;
		{addr, wdata, wr, rd, cmp, tcfg, acfg, balt, pat, pen} = '0;
		bext = 8'h3C;
		aext = 3'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_stby();
		t_reset();
		t_pat();
		t_porta();
		t_clocks();
		wrap_up();
	end

	// Whole run needs about 130 cycles; this 4000-cycle limit is far beyond it
	initial begin
		#20000;
		failures++;
		wrap_up();
	end
endmodule

bind iops_top iops_monitor #(.PORT_W(PORT_W)) i_iops_monitor (.*);
`default_nettype wire
